// >>> shared/otf_pkg.sv
/*
 offset trim and offset filter register bank: shared constants.
 assumes a 32-bit apb master; byte addresses are index times four.
*/
package otf_pkg;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned TRIM_W = 12;
  // printed offsets are not word aligned, so they are indices
  localparam logic [9:0] IDX_TRIM_C1_B = 10'h090;
  localparam logic [9:0] IDX_TRIM_C2_A = 10'h092;
  localparam logic [9:0] IDX_TRIM_C2_B = 10'h094;
  localparam logic [9:0] IDX_FILT_CTL0 = 10'h097;
  localparam logic [9:0] IDX_FILT_CTL1 = 10'h098;
  localparam logic [9:0] IDX_CAL_CTL = 10'h0a0;
  localparam logic [9:0] IDX_CAL_STAT = 10'h0a1;
  localparam logic [7:0] FILT_CTL0_RST = 8'h00;
  localparam logic [7:0] FILT_CTL1_RST = 8'h33;
  localparam logic [3:0] TRIM_UPPER_RST = 4'h0;
  localparam int unsigned KEEP_LF_BIT = 0;
  // calibration control fields
  localparam int unsigned FILT_EN_BIT = 0;
  localparam int unsigned BG_CAL_EN_BIT = 1;
  localparam int unsigned BG_OFS_EN_BIT = 2;
  localparam int unsigned OFS_CAL_EN_BIT = 3;
  // calibration status fields
  localparam int unsigned ST_FG_RUN_BIT = 0;
  localparam int unsigned ST_FG_CPL_BIT = 1;
  localparam int unsigned ST_HALT_BIT = 2;
  localparam int unsigned ST_WR_BLK_BIT = 3;
  localparam int unsigned ST_RD_BAD_BIT = 4;
  typedef enum logic [1:0] {
    OTF_FILT_OFF = 2'b01,
    OTF_FILT_ON = 2'b10
  } otf_filt_mode_t;
endpackage : otf_pkg

// >>> hw/otf_trim_store.sv
/*
 one trim register: 12-bit trim plus 4 writable upper bits.
 assumes a factory value on an input, caught at reset.
*/
`timescale 1ns/1ps
module otf_trim_store (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic [otf_pkg::TRIM_W-1:0] i_factory,
  input wire logic i_we,
  input wire logic [15:0] i_wdata,
  output logic [15:0] o_value
);
  logic [15:0] value_r;
  // synchronous reset, so loading the factory strap here is legal
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      value_r <= {otf_pkg::TRIM_UPPER_RST, i_factory};
    end else if (i_we) begin
      value_r <= i_wdata;
    end
  end
  assign o_value = value_r;
endmodule : otf_trim_store

// >>> hw/otf_offset_filter.sv
/*
 applies a trim to samples and the dc/mismatch offset filter.
 assumes one sample per clock and a bank mean estimate from outside.
*/
`timescale 1ns/1ps
module otf_offset_filter (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_enable,
  input wire logic i_keep_lf,
  input wire logic [otf_pkg::TRIM_W-1:0] i_trim,
  input wire logic [otf_pkg::TRIM_W-1:0] i_sample,
  input wire logic [otf_pkg::TRIM_W-1:0] i_bank_offset,
  input wire logic [otf_pkg::TRIM_W-1:0] i_common_offset,
  output logic [otf_pkg::TRIM_W-1:0] o_sample
);
  logic [otf_pkg::TRIM_W-1:0] trimmed, removed, out_r;
  otf_pkg::otf_filt_mode_t mode;
  assign trimmed = otf_pkg::TRIM_W'(i_sample - i_trim);
  assign mode = i_enable ? otf_pkg::OTF_FILT_ON : otf_pkg::OTF_FILT_OFF;
  always_comb begin
    // safe default keeps the mux free of latches
    removed = '0;
    unique case (mode)
      otf_pkg::OTF_FILT_ON: begin
        // keep_lf removes only the bank mismatch, keeping dc
        if (i_keep_lf) begin
          removed = otf_pkg::TRIM_W'(i_bank_offset - i_common_offset);
        end else begin
          removed = i_bank_offset;
        end
      end
      otf_pkg::OTF_FILT_OFF: begin
        removed = '0;
      end
    endcase
  end
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      out_r <= '0;
    end else begin
      out_r <= otf_pkg::TRIM_W'(trimmed - removed);
    end
  end
  assign o_sample = out_r;
endmodule : otf_offset_filter

// >>> hw/otf_regs.sv
/*
 apb register bank for offset trims and offset filter controls.
 assumes apb master on i_clk; calibration engine gives status inputs.
*/
// Implementation choice: register access over APB.
`timescale 1ns/1ps
module otf_regs #(
  parameter logic [otf_pkg::TRIM_W-1:0] FACTORY_C1_B = 12'h800,
  parameter logic [otf_pkg::TRIM_W-1:0] FACTORY_C2_A = 12'h800,
  parameter logic [otf_pkg::TRIM_W-1:0] FACTORY_C2_B = 12'h800
) (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [otf_pkg::ADDR_W-1:0] i_paddr,
  input wire logic [otf_pkg::DATA_W-1:0] i_pwdata,
  output logic o_pready,
  output logic [otf_pkg::DATA_W-1:0] o_prdata,
  output logic o_pslverr,
  input wire logic i_fg_cal_running,
  input wire logic i_foreground_calibration_complete,
  input wire logic i_calibration_halted,
  input wire logic i_sample_core1,
  input wire logic i_sample_core2,
  input wire logic i_analog_input_b,
  input wire logic [otf_pkg::TRIM_W-1:0] i_sample,
  input wire logic [otf_pkg::TRIM_W-1:0] i_bank_offset,
  input wire logic [otf_pkg::TRIM_W-1:0] i_common_offset,
  output logic [otf_pkg::TRIM_W-1:0] o_sample,
  output logic [otf_pkg::TRIM_W-1:0] o_active_trim,
  output logic [3:0] o_filter_bw,
  output logic [3:0] o_filter_soak
);
  function automatic logic [9:0] word_idx(input logic [otf_pkg::ADDR_W-1:0] a);
    word_idx = a[otf_pkg::ADDR_W-1:2];
  endfunction : word_idx

  logic access, wr, rd, trim_sel, wr_lock, rd_unsafe;
  logic [9:0] idx;
  logic [15:0] trim_c1_b, trim_c2_a, trim_c2_b;
  logic [7:0] filt_ctl0_r, filt_ctl1_r;
  logic [3:0] cal_ctl_r;
  logic wr_blocked_r, rd_unsafe_r;
  logic [otf_pkg::DATA_W-1:0] rdata_r;
  logic [otf_pkg::TRIM_W-1:0] active_trim_r;
  logic we_c1_b, we_c2_a, we_c2_b;

  assign o_pready = 1'b1;
  assign access = i_psel & i_penable;
  assign idx = word_idx(i_paddr);
  assign wr = access & i_pwrite;
  assign rd = access & ~i_pwrite;
  assign trim_sel = (idx == otf_pkg::IDX_TRIM_C1_B) | (idx == otf_pkg::IDX_TRIM_C2_A) |
                    (idx == otf_pkg::IDX_TRIM_C2_B);

  // trims are locked while the calibration engine owns them
  assign wr_lock = i_fg_cal_running |
                   (cal_ctl_r[otf_pkg::BG_CAL_EN_BIT] &
                    cal_ctl_r[otf_pkg::BG_OFS_EN_BIT]);
  // reads still answer; an unsafe read is only flagged
  assign rd_unsafe = (cal_ctl_r[otf_pkg::OFS_CAL_EN_BIT] & ~cal_ctl_r[otf_pkg::BG_OFS_EN_BIT] &
                      ~i_foreground_calibration_complete) |
                     (cal_ctl_r[otf_pkg::BG_CAL_EN_BIT] & cal_ctl_r[otf_pkg::BG_OFS_EN_BIT] &
                      ~i_calibration_halted);

  assign we_c1_b = wr & ~wr_lock & (idx == otf_pkg::IDX_TRIM_C1_B);
  assign we_c2_a = wr & ~wr_lock & (idx == otf_pkg::IDX_TRIM_C2_A);
  assign we_c2_b = wr & ~wr_lock & (idx == otf_pkg::IDX_TRIM_C2_B);

  otf_trim_store u_trim_c1_b (
    .i_clk(i_clk),
    .i_srst(i_srst),
    .i_factory(FACTORY_C1_B),
    .i_we(we_c1_b),
    .i_wdata(i_pwdata[15:0]),
    .o_value(trim_c1_b)
  );
  otf_trim_store u_trim_c2_a (
    .i_clk(i_clk),
    .i_srst(i_srst),
    .i_factory(FACTORY_C2_A),
    .i_we(we_c2_a),
    .i_wdata(i_pwdata[15:0]),
    .o_value(trim_c2_a)
  );
  otf_trim_store u_trim_c2_b (
    .i_clk(i_clk),
    .i_srst(i_srst),
    .i_factory(FACTORY_C2_B),
    .i_we(we_c2_b),
    .i_wdata(i_pwdata[15:0]),
    .o_value(trim_c2_b)
  );

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      filt_ctl0_r <= otf_pkg::FILT_CTL0_RST;
      filt_ctl1_r <= otf_pkg::FILT_CTL1_RST;
      cal_ctl_r <= '0;
    end else if (wr) begin
      if (idx == otf_pkg::IDX_FILT_CTL0) begin
        filt_ctl0_r <= i_pwdata[7:0];
      end
      if (idx == otf_pkg::IDX_FILT_CTL1) begin
        filt_ctl1_r <= i_pwdata[7:0];
      end
      if (idx == otf_pkg::IDX_CAL_CTL) begin
        cal_ctl_r <= i_pwdata[3:0];
      end
    end
  end

  // sticky diagnostics; set wins over the clear-by-write
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      wr_blocked_r <= 1'b0;
      rd_unsafe_r <= 1'b0;
    end else begin
      if (wr & trim_sel & wr_lock) begin
        wr_blocked_r <= 1'b1;
      end else if (wr & (idx == otf_pkg::IDX_CAL_STAT) & i_pwdata[otf_pkg::ST_WR_BLK_BIT]) begin
        wr_blocked_r <= 1'b0;
      end
      if (rd & trim_sel & rd_unsafe) begin
        rd_unsafe_r <= 1'b1;
      end else if (wr & (idx == otf_pkg::IDX_CAL_STAT) & i_pwdata[otf_pkg::ST_RD_BAD_BIT]) begin
        rd_unsafe_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      rdata_r <= '0;
    end else if (i_psel & ~i_penable & ~i_pwrite) begin
      rdata_r <= '0;
      unique case (word_idx(i_paddr))
        otf_pkg::IDX_TRIM_C1_B: rdata_r[15:0] <= trim_c1_b;
        otf_pkg::IDX_TRIM_C2_A: rdata_r[15:0] <= trim_c2_a;
        otf_pkg::IDX_TRIM_C2_B: rdata_r[15:0] <= trim_c2_b;
        otf_pkg::IDX_FILT_CTL0: rdata_r[7:0] <= filt_ctl0_r;
        otf_pkg::IDX_FILT_CTL1: rdata_r[7:0] <= filt_ctl1_r;
        otf_pkg::IDX_CAL_CTL: rdata_r[3:0] <= cal_ctl_r;
        otf_pkg::IDX_CAL_STAT: rdata_r[4:0] <= {rd_unsafe_r, wr_blocked_r,
                                               i_calibration_halted,
                                               i_foreground_calibration_complete,
                                               i_fg_cal_running};
        default: rdata_r <= '0;
      endcase
    end
  end
  assign o_prdata = rdata_r;
  // unmapped addresses read zero, writes ignored, no error
  assign o_pslverr = 1'b0;

  // trim chosen by which core samples which input
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      active_trim_r <= '0;
    end else if (i_sample_core1 & i_analog_input_b) begin
      active_trim_r <= trim_c1_b[otf_pkg::TRIM_W-1:0];
    end else if (i_sample_core2) begin
      active_trim_r <= i_analog_input_b ? trim_c2_b[otf_pkg::TRIM_W-1:0]
                                        : trim_c2_a[otf_pkg::TRIM_W-1:0];
    end else begin
      active_trim_r <= '0;
    end
  end
  assign o_active_trim = active_trim_r;
  assign o_filter_bw = filt_ctl1_r[7:4];
  assign o_filter_soak = filt_ctl1_r[3:0];

  otf_offset_filter u_filter (
    .i_clk(i_clk),
    .i_srst(i_srst),
    .i_enable(cal_ctl_r[otf_pkg::FILT_EN_BIT]),
    .i_keep_lf(filt_ctl0_r[otf_pkg::KEEP_LF_BIT]),
    .i_trim(active_trim_r),
    .i_sample(i_sample),
    .i_bank_offset(i_bank_offset),
    .i_common_offset(i_common_offset),
    .o_sample(o_sample)
  );
endmodule : otf_regs

// >>> dv/otf_regs_props.sv
/*
 port assertions for the offset trim register bank.
 assumes binding to otf_regs; pready is zero wait.
*/
`timescale 1ns/1ps
module otf_regs_props (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic o_pready,
  input wire logic [31:0] o_prdata,
  input wire logic o_pslverr,
  input wire logic i_sample_core1,
  input wire logic i_sample_core2,
  input wire logic i_analog_input_b,
  input wire logic [11:0] o_active_trim,
  input wire logic [3:0] o_filter_bw,
  input wire logic [3:0] o_filter_soak
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_srst);
  wire rds = i_psel && !i_penable && !i_pwrite;
  wire wra = i_psel && i_penable && i_pwrite && o_pready;
  wire [9:0] ix = i_paddr[11:2];
  wire c1w = wra && (ix == otf_pkg::IDX_FILT_CTL1);
  wire [2:0] sel = {i_sample_core1, i_sample_core2, i_analog_input_b};
  wire mapped = ix inside {otf_pkg::IDX_TRIM_C1_B, otf_pkg::IDX_TRIM_C2_A, otf_pkg::IDX_TRIM_C2_B,
    otf_pkg::IDX_FILT_CTL0, otf_pkg::IDX_FILT_CTL1, otf_pkg::IDX_CAL_CTL, otf_pkg::IDX_CAL_STAT};
  a_ready_no_err: assert property (o_pready && !o_pslverr) else $error("pready low or slverr");
  a_none_sel_zero: assert property (!i_sample_core1 && !i_sample_core2 |=> o_active_trim == 12'h000) else $error("trim with no core");
  // a trim write lands one cycle before the output can follow
  a_trim_steady: assert property ($stable(sel) && !$past(wra) && !$past(i_srst)
    |=> $stable(o_active_trim)) else $error("trim moved");
  a_rdata_hold: assert property (!rds |=> $stable(o_prdata)) else $error("prdata moved");
  a_unmapped_zero: assert property (rds && !mapped |=> o_prdata == 32'h0) else $error("gap read");
  a_ctl1_write: assert property (c1w |=> {o_filter_bw, o_filter_soak} == $past(i_pwdata[7:0]))
    else $error("ctl1 write lost");
  a_ctl1_hold: assert property (!c1w |=> $stable({o_filter_bw, o_filter_soak})) else $error("ctl1 moved");
  a_ctl1_reset: assert property ($fell(i_srst) |-> {o_filter_bw, o_filter_soak} == 8'h33) else $error("ctl1 reset");
  cover property (wra && ix == otf_pkg::IDX_TRIM_C2_A);
  cover property (rds && !mapped);
  cover property (c1w);
endmodule : otf_regs_props

// >>> dv/tb.sv
/*
 self-checking bench for otf_regs over apb.
 assumes zero-wait slave; factory trims set by parameter.
*/
`timescale 1ns/1ps
module tb;
  localparam logic [9:0] XB1 = otf_pkg::IDX_TRIM_C1_B;
  localparam logic [9:0] XA2 = otf_pkg::IDX_TRIM_C2_A;
  localparam logic [9:0] XB2 = otf_pkg::IDX_TRIM_C2_B;
  localparam logic [9:0] XF0 = otf_pkg::IDX_FILT_CTL0;
  localparam logic [9:0] XF1 = otf_pkg::IDX_FILT_CTL1;
  localparam logic [9:0] XCC = otf_pkg::IDX_CAL_CTL;
  localparam logic [9:0] XST = otf_pkg::IDX_CAL_STAT;
  logic i_clk = 1'b0, i_srst = 1'b1, i_psel = 1'b0, i_penable = 1'b0, i_pwrite = 1'b0;
  logic i_fg_cal_running = 1'b0, i_foreground_calibration_complete = 1'b0;
  logic i_calibration_halted = 1'b0, i_sample_core1 = 1'b0, i_sample_core2 = 1'b0;
  logic i_analog_input_b = 1'b0, o_pready, o_pslverr;
  logic [11:0] i_paddr = 12'h000, i_sample = 12'h100, i_bank_offset = 12'h010;
  logic [11:0] i_common_offset = 12'h004, o_sample, o_active_trim;
  logic [31:0] i_pwdata = 32'h0, o_prdata, rd;
  logic [3:0] o_filter_bw, o_filter_soak;
  int num_errors = 0, n_checks = 0;
  otf_regs #(.FACTORY_C1_B(12'h801), .FACTORY_C2_A(12'h802), .FACTORY_C2_B(12'h803)) dut_u (
    .i_clk, .i_srst, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .o_pready, .o_prdata,
    .o_pslverr, .i_fg_cal_running, .i_foreground_calibration_complete, .i_calibration_halted,
    .i_sample_core1, .i_sample_core2, .i_analog_input_b, .i_sample, .i_bank_offset,
    .i_common_offset, .o_sample, .o_active_trim, .o_filter_bw, .o_filter_soak);
  initial forever #5 i_clk = ~i_clk;
  task finish_test;
    $display("errors %0d checks %0d", num_errors, n_checks);
    if (num_errors == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : finish_test
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      $display("Error %s expected %h seen %h", nm, e, g);
      num_errors++;
    end
  endtask : chk
  task apb(input logic w, input logic [9:0] ix, input logic [31:0] d);
    @(posedge i_clk);
    {i_psel, i_penable, i_pwrite, i_paddr, i_pwdata} <= {1'b1, 1'b0, w, ix, 2'b00, d};
    @(posedge i_clk);
    i_penable <= 1'b1;
    // no wait limit here; only the watchdog ends a hung access
    do begin
      @(posedge i_clk);
    end while (o_pready !== 1'b1);
    rd = o_prdata;
    {i_psel, i_penable} <= 2'b00;
  endtask : apb
  task rchk(input logic [9:0] ix, input logic [31:0] e);
    apb(1'b0, ix, 32'h0);
    chk($sformatf("reg %h", ix), e, rd);
  endtask : rchk
  task t_reset;
    rchk(XB1, 32'h801);
    rchk(XA2, 32'h802);
    rchk(XB2, 32'h803);
    rchk(XF0, 32'h0);
    rchk(XF1, 32'h33);
    rchk(10'h096, 32'h0);
    chk("bw soak", 32'h33, {24'h0, o_filter_bw, o_filter_soak});
  endtask : t_reset
  task automatic t_rw;
    logic [9:0] ix [5] = '{XB1, XA2, XB2, XF0, 10'h093};
    logic [31:0] wv [5] = '{32'hf123, 32'ha456, 32'h5789, 32'h1a5, 32'h5555};
    logic [31:0] ev [5] = '{32'hf123, 32'ha456, 32'h5789, 32'ha5, 32'h0};
    foreach (ix[i]) apb(1'b1, ix[i], wv[i]);
    foreach (ix[i]) rchk(ix[i], ev[i]);
    apb(1'b1, XF1, 32'h47);
    rchk(XF1, 32'h47);
    chk("bw soak", 32'h47, {24'h0, o_filter_bw, o_filter_soak});
  endtask : t_rw
  task t_block;
    apb(1'b1, XA2, 32'h111);
    i_fg_cal_running <= 1'b1;
    apb(1'b1, XA2, 32'h222);
    i_fg_cal_running <= 1'b0;
    rchk(XA2, 32'h111);
    apb(1'b1, XCC, 32'h6);
    apb(1'b1, XA2, 32'h333);
    rchk(XA2, 32'h111);
    apb(1'b0, XST, 32'h0);
    chk("blocked flag", 32'h1, {31'h0, rd[3]});
    apb(1'b1, XCC, 32'h0);
    apb(1'b1, XST, 32'h18);
    apb(1'b1, XA2, 32'h444);
    rchk(XA2, 32'h444);
  endtask : t_block
  // only the flag that guards this mode is moved
  task t_rdsafe(input logic [31:0] cal, input logic use_halt);
    apb(1'b1, XCC, cal);
    for (int v = 0; v < 2; v++) begin
      if (use_halt) i_calibration_halted <= v[0];
      else i_foreground_calibration_complete <= v[0];
      apb(1'b0, XA2, 32'h0);
      apb(1'b0, XST, 32'h0);
      chk("unsafe flag", {31'h0, ~v[0]}, {31'h0, rd[4]});
      apb(1'b1, XST, 32'h18);
    end
    apb(1'b1, XCC, 32'h0);
  endtask : t_rdsafe
  task automatic t_filter;
    logic [11:0] rm [4] = '{12'h00c, 12'h010, 12'h000, 12'h000};
    apb(1'b1, XA2, 32'h20);
    i_sample_core2 <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, XCC, {31'h0, ~i[1]});
      apb(1'b1, XF0, {31'h0, ~i[0]});
      repeat (3) @(posedge i_clk);
      chk("trim", 32'h20, {20'h0, o_active_trim});
      chk("sample", {20'h0, 12'h0e0 - rm[i]}, {20'h0, o_sample});
    end
    {i_sample_core2, i_sample_core1, i_analog_input_b} <= 3'b011;
    repeat (3) @(posedge i_clk);
    chk("trim c1b", 32'h123, {20'h0, o_active_trim});
  endtask : t_filter
  initial begin
    repeat (3) @(posedge i_clk);
    i_srst <= 1'b0;
    t_reset();
    t_rw();
    t_block();
    t_rdsafe(32'h8, 1'b0);
    t_rdsafe(32'h6, 1'b1);
    t_filter();
    finish_test();
  end
  initial begin
    repeat (5000) @(posedge i_clk);
    num_errors++;
    finish_test();
  end
endmodule : tb
bind otf_regs otf_regs_props chk_u (.i_clk, .i_srst, .i_psel, .i_penable, .i_pwrite, .i_paddr,
  .i_pwdata, .o_pready, .o_prdata, .o_pslverr, .i_sample_core1, .i_sample_core2,
  .i_analog_input_b, .o_active_trim, .o_filter_bw, .o_filter_soak);
